// ===== logic/wdt_pkg.sv
/*
  Package for the watchdog time-out unit: register map, control fields,
  reset values, pulse length and the packed types shared by the top module.
  Assumes a single AHB-Lite slave on a 32-bit bus clocked by hclk.
*/
package wdt_pkg;

  localparam logic [31:0] WDT_BASE_ADDR   = 32'hFFFFAC00;
  localparam logic [7:0]  WDT_CTRL_OFS    = 8'h30;
  localparam logic [7:0]  WDT_COUNT_OFS   = 8'h34;
  localparam logic [7:0]  WDT_IRQ_STAT_OFS = 8'h38;
  localparam logic [7:0]  WDT_IRQ_MASK_OFS = 8'h3C;
  localparam logic [7:0]  WDT_CTRL_RESET  = 8'h00;
  localparam logic [31:0] WDT_COUNT_RESET = 32'h00000000;

  localparam int WDT_RUN_BIT   = 0;
  localparam int WDT_RSP_LO    = 1;
  localparam int WDT_LOCK_BIT  = 3;
  localparam int WDT_PER_LO    = 4;
  localparam int WDT_FIRST_BIT = 17;

  localparam logic [3:0] WDT_PULSE_CYCLES = 4'h8;

  // Sticky event bits: 0 time-out, 1 fast interrupt, 2 forced reset
  localparam int WDT_EVT_W = 3;

  typedef struct packed {
    logic       reserved;
    logic [2:0] period;
    logic       run_lock;
    logic [1:0] timeout_response;
    logic       run;
  } wdt_ctrl_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  offset;
  } wdt_req_t;

  typedef enum logic [1:0] {
    WDT_RSP_FIQ0 = 2'b00,
    WDT_RSP_FIQ1 = 2'b01,
    WDT_RSP_EXT  = 2'b10,
    WDT_RSP_SYS  = 2'b11
  } wdt_rsp_t;

endpackage : wdt_pkg

// ===== logic/wdt_top.sv
/*
  Watchdog time-out unit with AHB-Lite register slave, sticky event status,
  mask and one level interrupt. Assumes the system reset logic takes
  sys_reset_req and drives hresetn low in return.
*/
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module wdt_top (
  // Clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // AHB-Lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic        hready,
  input  wire  logic [31:0] hwdata,
  output logic       [31:0] hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Watchdog outputs
  output logic              fast_interrupt,
  output logic              reset_out_n,
  output logic              sys_reset_req,
  output logic              irq
);
  import wdt_pkg::*;

  wdt_ctrl_t              ctrl_reg;
  wdt_req_t               req_reg;
  logic [31:0]            count_reg;
  logic [31:0]            count_prev_reg;
  logic                   sel_prev;
  logic                   pulse_start;
  logic                   pending_reg;
  logic [3:0]             pulse_reg;
  logic [WDT_EVT_W-1:0]   stat_reg;
  logic [WDT_EVT_W-1:0]   mask_reg;
  logic                   timeout;
  logic                   fiq_mode;
  logic                   force_sys;
  logic                   wr_ctrl;
  logic                   wr_count;
  logic                   wr_stat;
  logic                   wr_mask;
  logic [WDT_EVT_W-1:0]   events;
  logic                   sel_bit;

  function automatic logic hit(input wdt_req_t r, input logic [7:0] ofs);
    hit = r.sel && r.write && (r.offset == ofs);
  endfunction : hit

  // period field selects bit 17 + 2*code
  function automatic logic pick_bit(input logic [31:0] value, input logic [2:0] code);
    pick_bit = value[WDT_FIRST_BIT + 2 * int'(code)];
  endfunction : pick_bit

  function automatic logic in_block(input logic [31:0] addr);
    in_block = (addr[31:8] == WDT_BASE_ADDR[31:8]);
  endfunction : in_block

  // Both samples use one code, so a period change fakes no edge
  always_comb begin
    sel_bit  = pick_bit(count_reg, ctrl_reg.period);
    sel_prev = pick_bit(count_prev_reg, ctrl_reg.period);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.sel    <= hsel && htrans[1] && in_block(haddr);
      req_reg.write  <= hwrite;
      req_reg.offset <= haddr[7:0];
    end
  end

  assign wr_ctrl  = hit(req_reg, WDT_CTRL_OFS);
  assign wr_count = hit(req_reg, WDT_COUNT_OFS);
  assign wr_stat  = hit(req_reg, WDT_IRQ_STAT_OFS);
  assign wr_mask  = hit(req_reg, WDT_IRQ_MASK_OFS);

  // rising edge of selected bit only
  assign timeout   = ctrl_reg.run && sel_bit && !sel_prev;
  // upper response bit clear selects interrupt
  assign fiq_mode  = !ctrl_reg.timeout_response[1];
  assign force_sys = timeout && fiq_mode && pending_reg;
  assign events    = {force_sys, timeout && fiq_mode && !pending_reg, timeout};
  assign pulse_start = timeout && (!fiq_mode || pending_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= WDT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg.reserved         <= 1'b0;
      ctrl_reg.period           <= hwdata[WDT_PER_LO +: 3];
      ctrl_reg.timeout_response <= hwdata[WDT_RSP_LO +: 2];
      // lock is set-only, freezes run bit
      ctrl_reg.run_lock         <= ctrl_reg.run_lock | hwdata[WDT_LOCK_BIT];
      if (!ctrl_reg.run_lock) begin
        ctrl_reg.run <= hwdata[WDT_RUN_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= WDT_COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= WDT_COUNT_RESET;
    end else if (ctrl_reg.run) begin
      // no stop or reload on time-out
      count_reg <= count_reg + 32'h00000001;
    end
  end

  // Last count is the edge reference; a clear only lowers the bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_prev_reg <= WDT_COUNT_RESET;
    end else begin
      count_prev_reg <= count_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_reg <= 1'b0;
    end else if (timeout && fiq_mode) begin
      pending_reg <= 1'b1;
    end else if (wr_count) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_interrupt <= 1'b0;
    end else begin
      fast_interrupt <= (pending_reg && !wr_count) || (timeout && fiq_mode);
    end
  end

  // eight-cycle low pulse on reset output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_reg <= 4'h0;
    end else if (pulse_start) begin
      pulse_reg <= WDT_PULSE_CYCLES;
    end else if (pulse_reg != 4'h0) begin
      pulse_reg <= pulse_reg - 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out_n <= 1'b1;
    end else begin
      reset_out_n <= !pulse_start && (pulse_reg <= 4'h1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_reset_req <= 1'b0;
    end else if (timeout && (ctrl_reg.timeout_response == WDT_RSP_SYS || pending_reg)) begin
      sys_reset_req <= 1'b1;
    end else if (pulse_reg <= 4'h1) begin
      sys_reset_req <= 1'b0;
    end
  end

  // Sticky status: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat ? hwdata[WDT_EVT_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= '0;
    end else if (wr_mask) begin
      mask_reg <= hwdata[WDT_EVT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Read data registered in address phase; count reads as zero (write-only)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite && in_block(haddr)) begin
      case (haddr[7:0])
        WDT_CTRL_OFS:     hrdata <= {24'h000000, ctrl_reg};
        WDT_IRQ_STAT_OFS: hrdata <= {29'h0, stat_reg};
        WDT_IRQ_MASK_OFS: hrdata <= {29'h0, mask_reg};
        default:          hrdata <= 32'h00000000;
      endcase
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : wdt_top

// ===== tb/wdt_assertions.sv
/*
  Port checker for the watchdog unit top, bound onto wdt_top.
  Assumes hclk only and async active-low hresetn.
*/
`timescale 1ns/10ps
module wdt_checker
  import wdt_pkg::*;
(
  // Watched ports
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        fast_interrupt,
  input wire logic        reset_out_n,
  input wire logic        sys_reset_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take_rd;
  logic take_clr;
  assign take_rd  = hsel && hready && htrans[1] && !hwrite;
  assign take_clr = hsel && hready && htrans[1] && hwrite
                    && haddr == WDT_BASE_ADDR + {24'h0, WDT_COUNT_OFS};
  bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
  bus_okay_a: assert property (!hresp) else $error("error response");
  ctrl_rsvd_a: assert property (
    take_rd && haddr == WDT_BASE_ADDR + {24'h0, WDT_CTRL_OFS} |=> hrdata[31:7] == 25'h0)
    else $error("control upper bits not zero");
  count_wo_a: assert property (
    take_rd && haddr == WDT_BASE_ADDR + {24'h0, WDT_COUNT_OFS} |=> hrdata == 32'h0)
    else $error("count register readable");
  idle_rdata_a: assert property (!take_rd |=> hrdata == 32'h0) else $error("stale read data");
  pulse_len_a: assert property (
    $fell(reset_out_n) |-> (!reset_out_n)[*8] ##1 reset_out_n) else $error("pulse length");
  sys_pair_a: assert property (
    sys_reset_req |-> !reset_out_n) else $error("request outside pulse");
  pend_clear_a: assert property (
    take_clr |-> ##[1:3] !fast_interrupt) else $error("interrupt not cleared");
  fiq_quiet_a: assert property (
    $rose(fast_interrupt) |-> reset_out_n && !sys_reset_req) else $error("reset on interrupt");
endmodule : wdt_checker

bind wdt_top wdt_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .fast_interrupt(fast_interrupt), .reset_out_n(reset_out_n),
  .sys_reset_req(sys_reset_req));

// ===== tb/wdt_sys_reset_model.sv
/*
  System reset logic stand-in: counts forced reset requests.
  Assumes requests are synchronous to hclk.
*/
`timescale 1ns/10ps
module wdt_sys_reset_model (
  // Watched signals
  input wire logic hclk,
  input wire logic sys_reset_req,
  // Observation
  output int       req_seen
);
  logic req_q = 1'h0;
  initial req_seen = 0;
  // Counted on rise so a long request is one reset
  always @(posedge hclk) begin
    req_q <= sys_reset_req;
    if (sys_reset_req && !req_q) req_seen <= req_seen + 1;
  end
endmodule : wdt_sys_reset_model

// ===== tb/test_watchdog_timeout_unit.sv
/*
  Testbench for wdt_top: register map, run lock, idle outputs.
  Assumes zero-wait AHB-Lite slave; time-outs lie beyond run length.
*/
`timescale 1ns/10ps
module test_watchdog_timeout_unit;
  import wdt_pkg::*;
  localparam logic [31:0] A_CTRL = WDT_BASE_ADDR + {24'h0, WDT_CTRL_OFS};
  localparam logic [31:0] A_CNT  = WDT_BASE_ADDR + {24'h0, WDT_COUNT_OFS};
  localparam logic [31:0] A_STAT = WDT_BASE_ADDR + {24'h0, WDT_IRQ_STAT_OFS};
  localparam logic [31:0] A_MASK = WDT_BASE_ADDR + {24'h0, WDT_IRQ_MASK_OFS};
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hready, hreadyout, hresp, fast_interrupt, reset_out_n, sys_reset_req, irq;
  int          err_count = 0, checks_done = 0, cycles = 0, req_seen;
  assign hready = hreadyout;
  wdt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fast_interrupt(fast_interrupt),
    .reset_out_n(reset_out_n), .sys_reset_req(sys_reset_req), .irq(irq));
  wdt_sys_reset_model sysm_u (.hclk(hclk), .sys_reset_req(sys_reset_req), .req_seen(req_seen));
  initial forever #20 hclk = ~hclk;
  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [31:0] a, e, input string nm);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(nm, e, r);
  endtask : rdc
  task automatic t_reset;
    rdc(A_CTRL, 32'h0, "control");
    chk("reset_out_n", 32'h1, {31'h0, reset_out_n});
  endtask : t_reset
  task automatic t_fields;
    wr(A_CTRL, 32'h76);
    rdc(A_CTRL, 32'h76, "control");
    wr(A_CTRL, 32'hFFFFFFF7);
    rdc(A_CTRL, 32'h77, "control");
    wr(A_CNT, 32'hA5A5A5A5);
    rdc(A_CNT, 32'h0, "count");
    rdc(WDT_BASE_ADDR + 32'h40, 32'h0, "unmapped");
  endtask : t_fields
  task automatic t_lock;
    wr(A_CTRL, 32'h7F);
    wr(A_CTRL, 32'h70);
    rdc(A_CTRL, 32'h79, "locked control");
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdc(A_CTRL, 32'h0, "control after reset");
  endtask : t_lock
  task automatic t_idle;
    wr(A_MASK, 32'h7);
    rdc(A_MASK, 32'h7, "mask");
    rdc(A_STAT, 32'h0, "status");
    // Longest period so no time-out lands in the run
    wr(A_CTRL, 32'h71);
    repeat (300) @(posedge hclk);
    chk("outputs", 32'h1, {28'h0, irq, fast_interrupt, sys_reset_req, reset_out_n});
    chk("requests", 32'h0, 32'(req_seen));
  endtask : t_idle
  task automatic t_count;
    logic [31:0] c;
    wr(A_CTRL, 32'h71);
    wr(A_CNT, 32'h0);
    @(posedge hclk);
    chk("count cleared", 32'h0, dut_u.count_reg);
    repeat (5) @(posedge hclk);
    chk("count steps", 32'h5, dut_u.count_reg);
    wr(A_CTRL, 32'h70);
    @(posedge hclk);
    c = dut_u.count_reg;
    repeat (3) @(posedge hclk);
    chk("count held", c, dut_u.count_reg);
  endtask : t_count
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_fields();
    t_lock();
    t_idle();
    t_count();
    end_of_test();
  end
endmodule : test_watchdog_timeout_unit
